// >>> core/tws_master.v
// Purpose: Two-wire bus master with status flags, interrupt mask and holding registers.
// Assumes: APB slave, zero wait states; open-drain SDA and SCL pins.
// Notes: No clock stretching; SDA changes one cycle after SCL falls.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"

module tws_master
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt
  output wire irq,
  // Serial data pin
  input wire sda_in,
  output wire sda_o,
  output wire sda_oe,
  // Serial clock pin
  output wire scl_o,
  output wire scl_oe
);

  localparam ST_IDLE = 7'b000_0001;
  localparam ST_START = 7'b000_0010;
  localparam ST_BYTE = 7'b000_0100;
  localparam ST_STOP_LO = 7'b000_1000;
  localparam ST_STOP_HI = 7'b001_0000;
  localparam ST_RSTA_LO = 7'b010_0000;
  localparam ST_RSTA_HI = 7'b100_0000;

  localparam K_ADDR = 2'd0;
  localparam K_IADR = 2'd1;
  localparam K_WDATA = 2'd2;
  localparam K_RDATA = 2'd3;

  reg soft_rst_r;
  reg master_transfer_enable_r, start_req_r, stop_req_r;
  reg [6:0] dev_addr_r;
  reg rd_dir_r;
  reg [1:0] iadr_sz_r;
  reg [23:0] iadr_r;
  reg [7:0] low_div_r, high_div_r;
  reg [2:0] div_exp_r;
  reg xfer_done_r, rx_ready_r, tx_ready_r, overrun_r, nack_r;
  reg [8:0] mask_r;
  reg [7:0] rx_byte_r, tx_byte_r;
  reg tx_full_r;
  reg [6:0] state_r;
  reg [1:0] kind_r, iadr_left_r;
  reg [3:0] bit_r;
  reg [7:0] shift_r;
  reg restarted_r, nack_pend_r, sda_drv_r, sda_oe_r;
  reg sda_m_r, sda_s_r;
  reg [31:0] prdata_r;
  reg hit;

  wire rst_n;
  wire setup, wr, rd;
  wire wr_cr, wr_mmr, wr_iadr, wr_cwgr, wr_ier, wr_idr, wr_thr, rd_sr, rd_rhr;
  wire [8:0] flags;
  wire scl_low, rise, fall, restart;
  wire [7:0] rx_full_byte;
  wire [7:0] iadr_byte;
  wire [1:0] iadr_idx;

  // ==========================================================================
  // Internal reset: power-on or one-cycle software reset pulse
  assign rst_n = presetn & ~soft_rst_r;

  // ==========================================================================
  // Input synchroniser
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
    end
  end

  // ==========================================================================
  // APB decode
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign wr_cr = wr & (paddr == `TWS_OFF_CTRL);
  assign wr_mmr = wr & (paddr == `TWS_OFF_MODE);
  assign wr_iadr = wr & (paddr == `TWS_OFF_INT_ADDR);
  assign wr_cwgr = wr & (paddr == `TWS_OFF_CLK_WAVE);
  assign wr_ier = wr & (paddr == `TWS_OFF_IRQ_SET);
  assign wr_idr = wr & (paddr == `TWS_OFF_IRQ_CLR);
  assign wr_thr = wr & (paddr == `TWS_OFF_TX_HOLD);
  assign rd_sr = rd & (paddr == `TWS_OFF_STATUS);
  assign rd_rhr = rd & (paddr == `TWS_OFF_RX_HOLD);

  always @*
  begin
    case (paddr)
      `TWS_OFF_CTRL, `TWS_OFF_MODE, `TWS_OFF_INT_ADDR, `TWS_OFF_CLK_WAVE,
      `TWS_OFF_STATUS, `TWS_OFF_IRQ_SET, `TWS_OFF_IRQ_CLR, `TWS_OFF_IRQ_MASK,
      `TWS_OFF_RX_HOLD, `TWS_OFF_TX_HOLD: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_r;

  assign flags = {nack_r, 1'b0, overrun_r, 3'h0, tx_ready_r, rx_ready_r, xfer_done_r};

  // ==========================================================================
  // Read data, captured in the setup phase
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_r <= `TWS_RST_WORD;
    else if (setup && !pwrite)
    begin
      case (paddr)
        `TWS_OFF_MODE: prdata_r <= {9'h0, dev_addr_r, 3'h0, rd_dir_r, 2'h0, iadr_sz_r, 8'h00};
        `TWS_OFF_INT_ADDR: prdata_r <= {8'h00, iadr_r};
        `TWS_OFF_CLK_WAVE: prdata_r <= {13'h0, div_exp_r, high_div_r, low_div_r};
        `TWS_OFF_STATUS: prdata_r <= {23'h0, flags};
        `TWS_OFF_IRQ_MASK: prdata_r <= {23'h0, mask_r};
        `TWS_OFF_RX_HOLD: prdata_r <= {24'h0, rx_byte_r};
        `TWS_OFF_TX_HOLD: prdata_r <= {24'h0, tx_byte_r};
        default: prdata_r <= `TWS_RST_WORD;
      endcase
    end
  end

  // ==========================================================================
  // Software reset pulse and configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= wr_cr & pwdata[`TWS_CTRL_SOFT_RESET];
  end

  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_addr_r <= 7'h00;
      rd_dir_r <= 1'b0;
      iadr_sz_r <= 2'h0;
      iadr_r <= 24'h00_0000;
      low_div_r <= 8'h00;
      high_div_r <= 8'h00;
      div_exp_r <= 3'h0;
      mask_r <= 9'h000;
    end
    else
    begin
      if (wr_mmr)
      begin
        dev_addr_r <= pwdata[`TWS_MODE_DEV_LSB +: 7];
        rd_dir_r <= pwdata[`TWS_MODE_READ];
        iadr_sz_r <= pwdata[`TWS_MODE_ISIZE_LSB +: 2];
      end
      if (wr_iadr)
        iadr_r <= pwdata[23:0];
      if (wr_cwgr)
      begin
        low_div_r <= pwdata[`TWS_WAVE_LOW_LSB +: 8];
        high_div_r <= pwdata[`TWS_WAVE_HIGH_LSB +: 8];
        div_exp_r <= pwdata[`TWS_WAVE_EXP_LSB +: 3];
      end
      if (wr_ier)
        mask_r <= mask_r | (pwdata[8:0] & `TWS_FLAG_BITS);
      else if (wr_idr)
        mask_r <= mask_r & ~pwdata[8:0];
    end
  end

  assign irq = |(flags & mask_r);

  // ==========================================================================
  // Serial clock timer
  assign restart = state_r[6] & fall;

  tws_scl_timer #(
    .DIV_W(8),
    .EXP_W(3),
    .CNT_W(16)
  ) u_timer (
    .pclk(pclk),
    .rst_n(rst_n),
    .en(~state_r[0]),
    .restart(restart),
    .low_div(low_div_r),
    .high_div(high_div_r),
    .div_exp(div_exp_r),
    .scl_low(scl_low),
    .rise(rise),
    .fall(fall)
  );

  assign scl_o = 1'b0;
  assign scl_oe = scl_low & (state_r[2] | state_r[3] | state_r[5]);
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;

  assign rx_full_byte = {shift_r[6:0], sda_s_r};
  assign iadr_idx = iadr_left_r - 2'd1;
  assign iadr_byte = iadr_r[{iadr_idx, 3'b000} +: 8];

  // ==========================================================================
  // Frame engine and status flags
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_transfer_enable_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      xfer_done_r <= 1'b0;
      rx_ready_r <= 1'b0;
      tx_ready_r <= 1'b0;
      overrun_r <= 1'b0;
      nack_r <= 1'b0;
      rx_byte_r <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_full_r <= 1'b0;
      state_r <= ST_IDLE;
      kind_r <= K_ADDR;
      iadr_left_r <= 2'h0;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      restarted_r <= 1'b0;
      nack_pend_r <= 1'b0;
      sda_drv_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      // SDA moves one cycle after SCL so data never changes with SCL high
      sda_oe_r <= sda_drv_r;
      // Bus side clears and commands; engine sets below take priority
      if (wr_cr)
      begin
        if (pwdata[`TWS_CTRL_START])
          start_req_r <= 1'b1;
        if (pwdata[`TWS_CTRL_STOP])
          stop_req_r <= 1'b1;
        if (pwdata[`TWS_CTRL_MASTER_DIS])
          master_transfer_enable_r <= 1'b0;
        else if (pwdata[`TWS_CTRL_MASTER_EN])
        begin
          master_transfer_enable_r <= 1'b1;
          xfer_done_r <= 1'b1;
          tx_ready_r <= 1'b1;
        end
      end
      if (rd_rhr)
        rx_ready_r <= 1'b0;
      if (rd_sr && prdata_r[`TWS_BIT_XFER_DONE])
        overrun_r <= 1'b0;
      if (rd_sr && prdata_r[`TWS_BIT_NACK])
        nack_r <= 1'b0;
      // byte to send in low bits
      if (wr_thr)
      begin
        tx_byte_r <= pwdata[7:0];
        tx_full_r <= 1'b1;
        tx_ready_r <= 1'b0;
      end

      case (state_r)
        ST_IDLE:
        begin
          if (master_transfer_enable_r && (start_req_r || (!rd_dir_r && tx_full_r)))
          begin
            state_r <= ST_START;
            start_req_r <= 1'b0;
            xfer_done_r <= 1'b0;
            sda_drv_r <= 1'b1;
            restarted_r <= 1'b0;
            nack_pend_r <= 1'b0;
            iadr_left_r <= iadr_sz_r;
            kind_r <= K_ADDR;
            shift_r <= {dev_addr_r, rd_dir_r & (iadr_sz_r == 2'h0)};
          end
        end
        ST_START:
        begin
          if (fall)
          begin
            state_r <= ST_BYTE;
            bit_r <= 4'h0;
            sda_drv_r <= ~shift_r[7];
          end
        end
        ST_BYTE:
        begin
          if (fall && bit_r < 4'd7)
          begin
            shift_r <= rx_full_byte;
            bit_r <= bit_r + 4'd1;
            sda_drv_r <= (kind_r != K_RDATA) & ~shift_r[6];
          end
          else if (fall && bit_r == 4'd7)
          begin
            bit_r <= 4'd8;
            shift_r <= rx_full_byte;
            sda_drv_r <= (kind_r == K_RDATA) & ~stop_req_r;
            if (kind_r == K_RDATA)
            begin
              rx_byte_r <= rx_full_byte;
              rx_ready_r <= 1'b1;
              if (rx_ready_r && !rd_rhr)
                overrun_r <= 1'b1;
            end
          end
          else if (fall)
          begin
            bit_r <= 4'h0;
            if (kind_r == K_RDATA)
            begin
              if (stop_req_r)
              begin
                state_r <= ST_STOP_LO;
                stop_req_r <= 1'b0;
                sda_drv_r <= 1'b1;
              end
              else
                sda_drv_r <= 1'b0;
            end
            else if (sda_s_r)
            begin
              nack_pend_r <= 1'b1;
              state_r <= ST_STOP_LO;
              stop_req_r <= 1'b0;
              sda_drv_r <= 1'b1;
            end
            else if (kind_r != K_WDATA && iadr_left_r != 2'h0)
            begin
              kind_r <= K_IADR;
              iadr_left_r <= iadr_idx;
              shift_r <= iadr_byte;
              sda_drv_r <= ~iadr_byte[7];
            end
            else if (kind_r == K_IADR && rd_dir_r && !restarted_r)
            begin
              state_r <= ST_RSTA_LO;
              restarted_r <= 1'b1;
              kind_r <= K_ADDR;
              shift_r <= {dev_addr_r, 1'b1};
              sda_drv_r <= 1'b0;
            end
            else if (rd_dir_r)
            begin
              kind_r <= K_RDATA;
              sda_drv_r <= 1'b0;
            end
            else if (tx_full_r)
            begin
              kind_r <= K_WDATA;
              shift_r <= tx_byte_r;
              sda_drv_r <= ~tx_byte_r[7];
              // set as byte moves to shifter
              if (!wr_thr)
              begin
                tx_full_r <= 1'b0;
                tx_ready_r <= 1'b1;
              end
            end
            else
            begin
              state_r <= ST_STOP_LO;
              stop_req_r <= 1'b0;
              sda_drv_r <= 1'b1;
            end
          end
        end
        ST_STOP_LO:
        begin
          if (rise)
            state_r <= ST_STOP_HI;
        end
        ST_STOP_HI:
        begin
          if (fall)
          begin
            state_r <= ST_IDLE;
            sda_drv_r <= 1'b0;
            xfer_done_r <= 1'b1;
            if (nack_pend_r)
            begin
              nack_r <= 1'b1;
              tx_ready_r <= 1'b1;
            end
          end
        end
        ST_RSTA_LO:
        begin
          if (rise)
            state_r <= ST_RSTA_HI;
        end
        ST_RSTA_HI:
        begin
          if (fall)
          begin
            state_r <= ST_START;
            sda_drv_r <= 1'b1;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          sda_drv_r <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> core/tws_map.vh
// Purpose: Register map, field positions and timing figures of the two-wire master.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes: Definitions only.
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ==========================================================================
// Register byte offsets
`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_MODE 8'h04
`define TWS_OFF_INT_ADDR 8'h0C
`define TWS_OFF_CLK_WAVE 8'h10
`define TWS_OFF_STATUS 8'h20
`define TWS_OFF_IRQ_SET 8'h24
`define TWS_OFF_IRQ_CLR 8'h28
`define TWS_OFF_IRQ_MASK 8'h2C
`define TWS_OFF_RX_HOLD 8'h30
`define TWS_OFF_TX_HOLD 8'h34

// ==========================================================================
// Control register command bits
`define TWS_CTRL_START 0
`define TWS_CTRL_STOP 1
`define TWS_CTRL_MASTER_EN 2
`define TWS_CTRL_MASTER_DIS 3
`define TWS_CTRL_SOFT_RESET 7

// ==========================================================================
// Status, enable, disable and mask bit positions
`define TWS_BIT_XFER_DONE 0
`define TWS_BIT_RX_READY 1
`define TWS_BIT_TX_READY 2
`define TWS_BIT_OVERRUN 6
`define TWS_BIT_NACK 8
`define TWS_FLAG_BITS 9'h147

// ==========================================================================
// Mode, internal address and clock waveform fields
`define TWS_MODE_DEV_LSB 16
`define TWS_MODE_READ 12
`define TWS_MODE_ISIZE_LSB 8
`define TWS_WAVE_LOW_LSB 0
`define TWS_WAVE_HIGH_LSB 8
`define TWS_WAVE_EXP_LSB 16

// ==========================================================================
// Reset values and timing
`define TWS_RST_WORD 32'h0000_0000
`define TWS_SCL_PHASE_EXTRA 3

`endif

// >>> core/tws_scl_timer.v
// Purpose: Times the serial clock high and low phases.
// Assumes: Runs on pclk; enable low parks the timer in the high phase.
// Notes: High phase comes first after enable or restart.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"

module tws_scl_timer
#(
  parameter DIV_W = 8,
  parameter EXP_W = 3,
  parameter CNT_W = 16
)
(
  // Clock and reset
  input wire pclk,
  input wire rst_n,
  // Control
  input wire en,
  input wire restart,
  input wire [DIV_W-1:0] low_div,
  input wire [DIV_W-1:0] high_div,
  input wire [EXP_W-1:0] div_exp,
  // Phase outputs
  output wire scl_low,
  output wire rise,
  output wire fall
);

  localparam [CNT_W-1:0] EXTRA = `TWS_SCL_PHASE_EXTRA;
  localparam [CNT_W-1:0] ONE = 1;

  reg [CNT_W-1:0] cnt_r;
  reg low_r;
  wire [CNT_W-1:0] low_len;
  wire [CNT_W-1:0] high_len;
  wire [CNT_W-1:0] last;
  wire term;

  // ==========================================================================
  // Phase length
  // exponent scales both
  assign low_len = ({{(CNT_W-DIV_W){1'b0}}, low_div} << div_exp) + EXTRA;
  assign high_len = ({{(CNT_W-DIV_W){1'b0}}, high_div} << div_exp) + EXTRA;
  assign last = (low_r ? low_len : high_len) - ONE;
  assign term = (cnt_r == last);

  // ==========================================================================
  // Counter
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= {CNT_W{1'b0}};
      low_r <= 1'b0;
    end
    else if (!en || restart)
    begin
      cnt_r <= {CNT_W{1'b0}};
      low_r <= 1'b0;
    end
    else if (term)
    begin
      cnt_r <= {CNT_W{1'b0}};
      low_r <= ~low_r;
    end
    else
    begin
      cnt_r <= cnt_r + ONE;
    end
  end

  assign scl_low = en & low_r;
  assign rise = en & term & low_r;
  assign fall = en & term & ~low_r;

endmodule
`default_nettype wire

// >>> bench/tws_master_monitor.sv
// Purpose: Port checker for the two-wire master.
// Assumes: Zero-wait APB; mask and clock waveform low-phase fields shadowed from bus writes.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module tws_master_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt and pins
  input wire logic irq,
  input wire logic sda_in,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic scl_o,
  input wire logic scl_oe
);
  logic [8:0] mask_r;
  logic [10:0] wave_r;
  logic [15:0] lo_cnt_r;
  logic [15:0] lo_len;
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic mapped;
  logic ctrl_en;
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign wr_acc = acc && pwrite;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2C,
                                8'h30, 8'h34};
  assign ctrl_en = wr_acc && paddr == 8'h00 && pwdata[2] && !pwdata[3] && !pwdata[7];
  assign lo_len = ({8'h00, wave_r[7:0]} << wave_r[10:8]) + 16'h0003;
  // ==========================================================================
  // Shadow of mask and low-phase setting
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_r <= 9'h000;
      wave_r <= 11'h000;
      lo_cnt_r <= 16'h0000;
    end
    else
    begin
      lo_cnt_r <= scl_oe ? lo_cnt_r + 16'h0001 : 16'h0000;
      if (wr_acc && paddr == 8'h24)
        mask_r <= mask_r | (pwdata[8:0] & 9'h147);
      if (wr_acc && paddr == 8'h28)
        mask_r <= mask_r & ~pwdata[8:0];
      if (wr_acc && paddr == 8'h10)
        wave_r <= {pwdata[18:16], pwdata[7:0]};
      if (wr_acc && paddr == 8'h00 && pwdata[7])
        mask_r <= 9'h000;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  unmapped_error_a: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access gave no error");
  mask_readback_a: assert property (rd_acc && paddr == 8'h2C |-> prdata == {23'h0, mask_r})
    else $error("mask read differs from enabled set");
  irq_flag_a: assert property (rd_acc && paddr == 8'h20 && |(prdata[8:1] & mask_r[8:1]) |-> irq)
    else $error("enabled flag set but interrupt low");
  irq_quiet_a: assert property (mask_r == 9'h000 |-> !irq)
    else $error("interrupt high with all sources disabled");
  rx_upper_a: assert property (rd_acc && paddr == 8'h30 |-> prdata[31:8] == 24'h0)
    else $error("receive hold upper bits not zero");
  scl_low_a: assert property ($fell(scl_oe) |-> lo_cnt_r == lo_len)
    else $error("serial clock low phase length wrong");
  master_transfer_enable_done_a: assert property (ctrl_en && mask_r[0] |=> irq)
    else $error("master enable did not raise completion");
  master_transfer_enable_ready_a: assert property (ctrl_en && mask_r[2] |=> irq)
    else $error("master enable did not raise transmit ready");
  thr_clear_a: assert property (wr_acc && paddr == 8'h34 && mask_r == 9'h004 |=> !irq)
    else $error("transmit ready stayed set after hold write");
  cover property (rd_acc && paddr == 8'h20 && prdata[8]);
  cover property (rd_acc && paddr == 8'h20 && prdata[6]);
  cover property ($fell(scl_oe));
endmodule
`default_nettype wire

// >>> bench/tws_slave_model.sv
// Purpose: Behavioural slave on the two-wire bus.
// Assumes: Lines pulled up; changes data only while the clock is low.
// Notes: Can refuse data bytes and read addresses on command; sends rd_byte each read byte until the master does not acknowledge.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Scenario controls
  input wire logic nack_data,
  input wire logic [7:0] rd_byte,
  // Outputs
  output var logic sda_pull,
  output var logic [7:0] got_byte
);
  int bitn = 0;
  logic [7:0] sh = 8'h00;
  logic addr_ph = 1'b0;
  logic rd_mode = 1'b0;
  initial sda_pull = 1'b0;
  initial got_byte = 8'h00;
  // Start condition restarts the byte
  always @(negedge sda)
  begin
    if (scl)
    begin
      bitn = 0;
      addr_ph = 1'b1;
      rd_mode = 1'b0;
    end
  end
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    bitn = bitn + 1;
  end
  // Ack, data bits and release at each falling clock
  always @(negedge scl)
  begin
    if (bitn == 8)
    begin
      if (addr_ph)
        rd_mode = sh[0] && !nack_data;
      else if (!rd_mode)
        got_byte = sh;
      sda_pull = addr_ph ? (!sh[0] || rd_mode) : (!rd_mode && !nack_data);
    end
    else if (bitn == 9)
    begin
      if (rd_mode && !addr_ph && sh[0])
        rd_mode = 1'b0;
      bitn = 0;
      addr_ph = 1'b0;
      sda_pull = 1'b0;
    end
    if (rd_mode && !addr_ph && bitn < 8)
      sda_pull = !rd_byte[7 - bitn];
  end
endmodule
`default_nettype wire

// >>> bench/tws_master_test.sv
// Purpose: Self-checking bench for the two-wire master.
// Assumes: 10 MHz pclk; zero-wait APB slave.
// Notes: Slave model answers on the open-drain lines.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"
module tws_master_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic nack_data = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic irq;
  wire logic sda_oe;
  wire logic scl_oe;
  wire logic scl;
  wire logic sda;
  wire logic sda_pull;
  wire logic [7:0] got_byte;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] st;
  logic err;
  assign scl = !scl_oe;
  assign sda = !(sda_oe || sda_pull);
  tws_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sda_in(sda), .sda_o(), .sda_oe(sda_oe), .scl_o(),
    .scl_oe(scl_oe));
  tws_slave_model slave (.scl(scl), .sda(sda), .nack_data(nack_data), .rd_byte(rd_byte),
    .sda_pull(sda_pull), .got_byte(got_byte));
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      fail_count++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0000_0000, st, err);
    chk(nm, ex, st);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, st, err);
  endtask
  // Waits for the frame to start, then polls status until it completes
  task automatic run_frame(output logic [31:0] s);
    logic e;
    while (scl_oe !== 1'b1)
    begin
      @(posedge pclk);
    end
    do
    begin
      apb(1'b0, `TWS_OFF_STATUS, 32'h0000_0000, s, e);
    end
    while (s[0] !== 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    fail_count++;
    report_and_stop();
  end
  // ==========================================================================
  // Tests
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TWS_OFF_STATUS, 32'h0000_0000, "status reset");
    rd(`TWS_OFF_IRQ_MASK, 32'h0000_0000, "mask reset");
    rd(`TWS_OFF_RX_HOLD, 32'h0000_0000, "rx hold reset");
    apb(1'b0, 8'h08, 32'h0000_0000, st, err);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    wr(`TWS_OFF_IRQ_SET, 32'h0000_0147);
    rd(`TWS_OFF_IRQ_MASK, 32'h0000_0147, "mask all");
    wr(`TWS_OFF_IRQ_CLR, 32'h0000_0042);
    wr(`TWS_OFF_IRQ_SET, 32'h0000_0000);
    wr(`TWS_OFF_IRQ_CLR, 32'h0000_0000);
    rd(`TWS_OFF_IRQ_MASK, 32'h0000_0105, "mask partial");
    wr(`TWS_OFF_CLK_WAVE, 32'h0001_0101);
    wr(`TWS_OFF_MODE, 32'h0050_0000);
    wr(`TWS_OFF_CTRL, 32'h0000_0004);
    rd(`TWS_OFF_STATUS, 32'h0000_0005, "status enabled");
    @(posedge pclk);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    wr(`TWS_OFF_IRQ_CLR, 32'h0000_0147);
    @(posedge pclk);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
    wr(`TWS_OFF_IRQ_SET, 32'h0000_0004);
    wr(`TWS_OFF_TX_HOLD, 32'h0000_00A5);
    @(posedge pclk);
    chk("irq tx ready", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, `TWS_OFF_STATUS, 32'h0000_0000, st, err);
    chk("tx ready low", 32'h0000_0000, st & 32'h0000_0004);
    run_frame(st);
    chk("write done", 32'h0000_0005, st);
    chk("sent byte", 32'h0000_00A5, {24'h0, got_byte});
    nack_data <= 1'b1;
    wr(`TWS_OFF_TX_HOLD, 32'h0000_005A);
    run_frame(st);
    chk("nack done", 32'h0000_0105, st);
    rd(`TWS_OFF_STATUS, 32'h0000_0005, "nack cleared");
    wr(`TWS_OFF_MODE, 32'h0050_1000);
    wr(`TWS_OFF_CTRL, 32'h0000_0001);
    run_frame(st);
    chk("read addr nack", 32'h0000_0105, st);
    nack_data <= 1'b0;
    wr(`TWS_OFF_MODE, 32'h0050_1000);
    rd_byte <= 8'h3C;
    wr(`TWS_OFF_CTRL, 32'h0000_0003);
    run_frame(st);
    chk("read one", 32'h0000_0007, st);
    rd_byte <= 8'hC3;
    wr(`TWS_OFF_CTRL, 32'h0000_0003);
    run_frame(st);
    chk("overrun set", 32'h0000_0047, st);
    rd(`TWS_OFF_STATUS, 32'h0000_0007, "overrun cleared");
    rd(`TWS_OFF_RX_HOLD, 32'h0000_00C3, "rx byte");
    rd(`TWS_OFF_STATUS, 32'h0000_0005, "rx ready cleared");
    wr(`TWS_OFF_CTRL, 32'h0000_0080);
    rd(`TWS_OFF_IRQ_MASK, 32'h0000_0000, "mask soft reset");
    rd(`TWS_OFF_STATUS, 32'h0000_0000, "status soft reset");
    report_and_stop();
  end
endmodule
bind tws_master tws_master_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .sda_in(sda_in), .sda_o(sda_o),
  .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe));
`default_nettype wire
